// ==== design/alpha_ucs2_pkg.sv ====
package alpha_ucs2_pkg;

  // ----------------------------------------
  // Scheme tags and byte values
  // ----------------------------------------
  localparam logic [7:0]  TAG_DIRECT  = 8'h80;
  localparam logic [7:0]  TAG_PTR8    = 8'h81;
  localparam logic [7:0]  TAG_PTR16   = 8'h82;
  localparam logic [7:0]  PAD_BYTE    = 8'hFF;
  localparam int          TOP_BIT     = 7;
  localparam logic [15:0] BASE_MASK8  = 16'h7F80;
  localparam int          BASE8_SHIFT = 7;
  localparam logic [15:0] CHAR_RESET  = 16'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } in_byte_s;

  typedef struct packed {
    logic [15:0] code;
    logic        wide;
    logic        last;
  } out_char_s;

  typedef enum logic [6:0] {
    ST_TAG   = 7'b000_0001,
    ST_COUNT = 7'b000_0010,
    ST_BASEH = 7'b000_0100,
    ST_BASEL = 7'b000_1000,
    ST_BODY  = 7'b001_0000,
    ST_PAIR  = 7'b010_0000,
    ST_DRAIN = 7'b100_0000
  } dec_state_e;

endpackage : alpha_ucs2_pkg

// ==== design/alpha_field_ucs2_decoder.sv ====
// Summary of operation
// - Tag 80: byte pairs form UCS2, high first
// - Tag 80: FF padding and odd byte dropped
// - Tag 81: count, then base byte shifted seven
// - Tag 81: top bit picks alphabet or offset
// - Tag 82: count, then sixteen-bit base, high first
// - Tag 82: top bit picks alphabet or offset
// - Pointer schemes: count bounds, FF is character
// - Record uses exactly one scheme
`timescale 1ns/10ps
`default_nettype none

module alpha_field_ucs2_decoder
  import alpha_ucs2_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      reset_i,
  input  wire in_byte_s  in_byte_i,
  input  wire logic      in_valid_i,
  output logic           in_ready_o,
  output out_char_s      out_char_o,
  output logic           out_valid_o,
  input  wire logic      out_ready_i,
  output logic           scheme_error_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] body_char(input logic [7:0] b, input logic [15:0] base);
    body_char = b[TOP_BIT] ? base + {9'h000, b[6:0]} : {9'h000, b[6:0]};
  endfunction : body_char

  // ----------------------------------------
  // State
  // ----------------------------------------
  dec_state_e  state_q, state_d;
  logic [7:0]  tag_q, tag_d;
  logic [7:0]  count_q, count_d;
  logic [15:0] base_q, base_d;
  logic [7:0]  hi_q, hi_d;
  logic        err_q, err_d;

  // Two-entry skid buffer
  out_char_s   buf_q [2];
  logic [1:0]  fill_q;
  logic        rd_q, wr_q;

  wire logic       buf_ready = (fill_q != 2'd2);
  wire logic       take      = in_valid_i && buf_ready;
  wire logic [7:0] b         = in_byte_i.data;
  wire logic       lst       = in_byte_i.last;
  wire logic       is_ptr    = (tag_q == TAG_PTR8) || (tag_q == TAG_PTR16);

  logic      push;
  out_char_s push_c;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    tag_d   = tag_q;
    count_d = count_q;
    base_d  = base_q;
    hi_d    = hi_q;
    err_d   = err_q;
    push    = 1'b0;
    push_c  = '{code: CHAR_RESET, wide: 1'b0, last: 1'b0};
    if (take) begin
      case (state_q)
        ST_TAG: begin
          tag_d = b;
          err_d = 1'b0;
          if (b == TAG_DIRECT) begin
            state_d = lst ? ST_TAG : ST_PAIR;
          end else if (b == TAG_PTR8 || b == TAG_PTR16) begin
            state_d = lst ? ST_TAG : ST_COUNT;
          end else begin
            push    = 1'b1;
            push_c  = '{code: {9'h000, b[6:0]}, wide: 1'b0, last: lst};
            state_d = lst ? ST_TAG : ST_BODY;
          end
        end
        ST_COUNT: begin
          count_d = b;
          state_d = lst ? ST_TAG : ST_BASEH;
        end
        ST_BASEH: begin
          if (tag_q == TAG_PTR8) begin
            base_d  = ({8'h00, b} << BASE8_SHIFT) & BASE_MASK8;
          end else begin
            base_d  = {b, 8'h00};
          end
          if (lst) begin
            state_d = ST_TAG;
          end else if (tag_q == TAG_PTR8) begin
            state_d = (count_q == 8'h00) ? ST_DRAIN : ST_BODY;
          end else begin
            state_d = ST_BASEL;
          end
        end
        ST_BASEL: begin
          base_d  = {base_q[15:8], b};
          state_d = lst ? ST_TAG : ((count_q == 8'h00) ? ST_DRAIN : ST_BODY);
        end
        ST_BODY: begin
          if (is_ptr) begin
            push    = 1'b1;
            push_c  = '{code: body_char(b, base_q), wide: b[TOP_BIT],
                        last: lst || (count_q == 8'h01)};
            count_d = count_q - 8'h01;
            if (lst) begin
              state_d = ST_TAG;
            end else if (count_q == 8'h01) begin
              state_d = ST_DRAIN;
            end
          end else begin
            // top bit set outside a wide scheme is a mixed record
            err_d   = err_q | b[TOP_BIT];
            push    = 1'b1;
            push_c  = '{code: {9'h000, b[6:0]}, wide: 1'b0, last: lst};
            state_d = lst ? ST_TAG : ST_BODY;
          end
        end
        ST_PAIR: begin
          if (hi_q == PAD_BYTE && tag_q == TAG_DIRECT && count_q[0]) begin
            // low half; an FFFF pair is padding
            if (!(hi_q == PAD_BYTE && b == PAD_BYTE)) begin
              push   = 1'b1;
            end
            push_c  = '{code: {hi_q, b}, wide: 1'b1, last: lst};
            count_d = 8'h00;
          end else if (count_q[0]) begin
            push    = 1'b1;
            push_c  = '{code: {hi_q, b}, wide: 1'b1, last: lst};
            count_d = 8'h00;
          end else begin
            hi_d    = b;
            count_d = 8'h01;
          end
          state_d = lst ? ST_TAG : ST_PAIR;
        end
        default: begin
          // Past the counted length: remaining bytes are padding
          state_d = lst ? ST_TAG : ST_DRAIN;
        end
      endcase
      if (lst && state_d == ST_TAG) begin
        count_d = 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state_q <= ST_TAG;
      tag_q   <= 8'h00;
      count_q <= 8'h00;
      base_q  <= CHAR_RESET;
      hi_q    <= 8'h00;
      err_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      tag_q   <= tag_d;
      count_q <= count_d;
      base_q  <= base_d;
      hi_q    <= hi_d;
      err_q   <= err_d;
    end
  end

  // A padding pair that closes the string still has to mark the end
  wire logic       pad_end = take && lst && !push && (fill_q != 2'd0);
  wire logic       pop     = out_valid_o && out_ready_i;
  wire logic [1:0] fill_d  = fill_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      fill_q <= 2'd0;
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
    end else begin
      fill_q <= fill_d;
      if (pop) rd_q <= ~rd_q;
      if (push) wr_q <= ~wr_q;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (push) buf_q[wr_q] <= push_c;
      if (pad_end) buf_q[~wr_q].last <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs, registered
  // ----------------------------------------
  wire logic       rd_next  = pop ? ~rd_q : rd_q;
  // New char is head when the buffer empties under it; its slot is only written on this edge
  wire logic       head_new = push && (fill_q == {1'b0, pop});
  wire out_char_s  head_d   = head_new ? push_c : buf_q[rd_next];

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      out_valid_o    <= 1'b0;
      out_char_o     <= '0;
      in_ready_o     <= 1'b0;
      scheme_error_o <= 1'b0;
    end else begin
      out_valid_o    <= (fill_d != 2'd0);
      out_char_o     <= head_d;
      if (pad_end && fill_d == 2'd1) out_char_o.last <= 1'b1;
      in_ready_o     <= (fill_d == 2'd0) || (fill_d == 2'd1 && !push);
      scheme_error_o <= err_d;
    end
  end

endmodule : alpha_field_ucs2_decoder

`default_nettype wire

// ==== tb/alpha_ucs2_decoder_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module alpha_ucs2_decoder_checker
  import alpha_ucs2_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      reset_i,
  input wire in_byte_s  in_byte_i,
  input wire logic      in_valid_i,
  input wire logic      in_ready_o,
  input wire out_char_s out_char_o,
  input wire logic      out_valid_o,
  input wire logic      out_ready_i,
  input wire logic      scheme_error_o
);
  // ----------------------------------------
  // Field tracking
  // ----------------------------------------
  logic [7:0]  idx_q, tag_q, cnt_q, nout_q;
  logic [15:0] base_q;
  logic        take, ptr, ov;
  assign take = in_valid_i && in_ready_o;
  assign ptr  = tag_q == TAG_PTR8 || tag_q == TAG_PTR16;
  assign ov   = out_valid_o;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      idx_q  <= 8'h00;
      tag_q  <= 8'h00;
      cnt_q  <= 8'h00;
      nout_q <= 8'h00;
      base_q <= 16'h0000;
    end else begin
      if (take) idx_q <= in_byte_i.last ? 8'h00 : idx_q + 8'h01;
      if (take && idx_q == 8'h00) tag_q <= in_byte_i.data;
      if (take && idx_q == 8'h01) cnt_q <= in_byte_i.data;
      if (take && idx_q == 8'h02) base_q[15:8] <= in_byte_i.data;
      if (take && idx_q == 8'h03) base_q[7:0] <= in_byte_i.data;
      if (take && idx_q == 8'h00) nout_q <= 8'h00;
      else if (ov && out_ready_i) nout_q <= nout_q + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_stall;
    ov && !out_ready_i |=> ov && $stable(out_char_o);
  endproperty
  a_stall: assert property (p_stall) else $error("output moved while stalled");
  property p_direct_wide;
    ov && tag_q == TAG_DIRECT |-> out_char_o.wide;
  endproperty
  a_direct_wide: assert property (p_direct_wide) else $error("direct char not wide");
  property p_no_pad;
    ov && tag_q == TAG_DIRECT |-> out_char_o.code != 16'hFFFF;
  endproperty
  a_no_pad: assert property (p_no_pad) else $error("padding emitted");
  property p_base8_top;
    ov && tag_q == TAG_PTR8 |-> !out_char_o.code[15];
  endproperty
  a_base8_top: assert property (p_base8_top) else $error("base bit 15 set");
  property p_base8;
    ov && tag_q == TAG_PTR8 && out_char_o.wide |-> out_char_o.code[15:7] == {1'b0, base_q[15:8]};
  endproperty
  a_base8: assert property (p_base8) else $error("half page base wrong");
  property p_base16;
    ov && tag_q == TAG_PTR16 && out_char_o.wide |-> 16'(out_char_o.code - base_q) < 16'h0080;
  endproperty
  a_base16: assert property (p_base16) else $error("offset outside half page");
  property p_alpha7;
    ov && ptr && !out_char_o.wide |-> out_char_o.code[15:7] == 9'h000;
  endproperty
  a_alpha7: assert property (p_alpha7) else $error("alphabet char too wide");
  property p_count;
    ov && out_ready_i && ptr |-> nout_q < cnt_q;
  endproperty
  a_count: assert property (p_count) else $error("more chars than count");
  property p_single;
    ov && !ptr && tag_q != TAG_DIRECT |-> !out_char_o.wide;
  endproperty
  a_single: assert property (p_single) else $error("wide char in plain record");
endmodule : alpha_ucs2_decoder_checker
bind alpha_field_ucs2_decoder alpha_ucs2_decoder_checker u_chk (.core_clk_i(core_clk_i),
  .reset_i(reset_i), .in_byte_i(in_byte_i), .in_valid_i(in_valid_i), .in_ready_o(in_ready_o),
  .out_char_o(out_char_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .scheme_error_o(scheme_error_o));
`default_nettype wire

// ==== tb/char_sink.sv ====
`timescale 1ns/10ps
`default_nettype none
module char_sink
  import alpha_ucs2_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire out_char_s char_i,
  input  wire logic      valid_i,
  input  wire logic      slow_i,
  output logic           ready_o
);
  logic [17:0] rx_q[$];
  logic [1:0]  ph = 2'd0;
  initial ready_o = 1'b0;
  // Slow mode accepts one cycle in four so the buffer fills
  always @(posedge core_clk_i) begin
    if (valid_i === 1'b1 && ready_o === 1'b1) rx_q.push_back({char_i.last, char_i.wide, char_i.code});
    ph = ph + 2'd1;
    ready_o <= #1 slow_i ? (ph == 2'd3) : 1'b1;
  end
endmodule : char_sink
`default_nettype wire

// ==== tb/alpha_field_ucs2_decoder_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module alpha_field_ucs2_decoder_tb;
  import alpha_ucs2_pkg::*;
  logic      core_clk_i = 1'b0;
  logic      reset_i    = 1'b1;
  logic      in_valid_i = 1'b0;
  logic      slow       = 1'b0;
  in_byte_s  in_byte_i  = '0;
  logic      in_ready_o, out_valid_o, out_ready_i, scheme_error_o;
  out_char_s out_char_o;
  int        mismatches = 0;
  int        n_tests    = 0;
  int        cycles     = 0;
  always #4 core_clk_i = ~core_clk_i;
  alpha_field_ucs2_decoder u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .in_byte_i(in_byte_i),
    .in_valid_i(in_valid_i), .in_ready_o(in_ready_o), .out_char_o(out_char_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .scheme_error_o(scheme_error_o));
  char_sink u_sink (.core_clk_i(core_clk_i), .char_i(out_char_o), .valid_i(out_valid_o),
    .slow_i(slow), .ready_o(out_ready_i));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Valid only offered while ready is high: the core may take despite low ready
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      while (in_ready_o !== 1'b1) begin
        in_valid_i = 1'b0;
        @(posedge core_clk_i);
        #1;
      end
      in_byte_i  = {b[i], 1'(i == b.size() - 1)};
      in_valid_i = 1'b1;
      @(posedge core_clk_i);
      #1;
    end
    in_valid_i = 1'b0;
    // Idle edge so a following field never re-raises valid in the same step
    @(posedge core_clk_i);
    #1;
  endtask : send
  task automatic expect_all(input logic [17:0] e[$]);
    int w;
    w = 0;
    while (u_sink.rx_q.size() < e.size() && w < 300) begin
      @(posedge core_clk_i);
      w++;
    end
    repeat (8) @(posedge core_clk_i);
    #1;
    check(18'(u_sink.rx_q.size()), 18'(e.size()));
    foreach (e[i]) if (i < u_sink.rx_q.size()) check(u_sink.rx_q[i], e[i]);
    u_sink.rx_q.delete();
  endtask : expect_all
  task automatic t_direct();
    // Fast consumer drains ABCD before the pad closes the field: no end mark left to patch
    send({8'h80, 8'h12, 8'h34, 8'hAB, 8'hCD, 8'hFF, 8'hFF, 8'hFF});
    expect_all({18'h1_1234, 18'h1_ABCD});
    send({8'h80, 8'h12, 8'h34, 8'hAB, 8'hCD});
    expect_all({18'h1_1234, 18'h3_ABCD});
  endtask : t_direct
  task automatic t_ptr8();
    slow = 1'b1;
    send({8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41, 8'hFF, 8'hFF});
    expect_all({18'h0_0053, 18'h1_0995, 18'h1_09A6, 18'h0_0041, 18'h3_09FF});
    slow = 1'b0;
  endtask : t_ptr8
  task automatic t_ptr16();
    send({8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31});
    expect_all({18'h0_002D, 18'h1_0532, 18'h1_0583, 18'h0_002D, 18'h2_0031});
  endtask : t_ptr16
  task automatic t_plain();
    // Count zero: header only, trailing byte swallowed, next field still decoded
    send({8'h81, 8'h00, 8'h13, 8'h41});
    send({8'h41, 8'h42});
    expect_all({18'h0_0041, 18'h2_0042});
    check(18'(scheme_error_o), 18'h0_0000);
    send({8'h41, 8'hC2});
    expect_all({18'h0_0041, 18'h2_0042});
    check(18'(scheme_error_o), 18'h0_0001);
  endtask : t_plain
  initial begin
    repeat (5) @(posedge core_clk_i);
    #1 reset_i = 1'b0;
    t_direct();
    t_ptr8();
    t_ptr16();
    t_plain();
    report_and_stop();
  end
endmodule : alpha_field_ucs2_decoder_tb
`default_nettype wire
